// file: src/afe_ctrl_pkg.sv
// Shared constants, register layout and carrier types for the front-end control block.
// Assumes a single 250 MHz system clock; every other rate arrives as a pin that is resampled.
package afe_ctrl_pkg;

  // Timing.
  localparam int CLK_MHZ     = 250;
  localparam int POR_TIME_US = 1000;
  localparam int POR_CYCLES  = POR_TIME_US * CLK_MHZ;
  localparam int POR_CNT_W   = 18;

  // Widths.
  localparam int WORD_W     = 12;
  localparam int ADDR_W     = 4;
  localparam int GAIN_W     = 10;
  localparam int GAIN_DB_W  = 14;
  localparam int CLAMP_W    = 8;
  localparam int PIPE_DEPTH = 9;
  localparam int NUM_REGS   = 5;

  // Register addresses on the serial link.
  localparam logic [ADDR_W-1:0] ADDR_OPERATION = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL   = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_CLAMP     = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_GAIN      = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_STARTUP   = 4'hd;

  // Pending-write slots, one per register.
  localparam int SLOT_OPERATION = 0;
  localparam int SLOT_CONTROL   = 1;
  localparam int SLOT_CLAMP     = 2;
  localparam int SLOT_GAIN      = 3;
  localparam int SLOT_STARTUP   = 4;

  // Field positions.
  localparam int OP_SOFT_RESET  = 0;
  localparam int OP_POWER_LSB   = 1;
  localparam int OP_CLAMP_OFF   = 3;
  localparam int OP_BLANK_LEVEL = 6;
  localparam int CTL_CLAMP_POL  = 2;
  localparam int CTL_BLANK_POL  = 3;
  localparam int CTL_OUT_HIZ    = 4;
  localparam int CTL_GRAY       = 6;

  // Reset and magic values.
  localparam logic [WORD_W-1:0]  RESET_WORD    = 12'h000;
  localparam logic [CLAMP_W-1:0] RESET_CLAMP   = 8'h80;
  localparam logic [GAIN_W-1:0]  RESET_GAIN    = 10'h000;
  localparam logic [WORD_W-1:0]  STARTUP_VALUE = 12'h838;

  // Gain in units of 0.005 dB: 0.035 dB per step is 7 units, 5.3 dB is 1060 units.
  localparam logic [GAIN_DB_W-1:0] GAIN_STEP   = 14'h0007;
  localparam logic [GAIN_DB_W-1:0] GAIN_OFFSET = 14'h0424;

  typedef struct packed {
    logic              blank;
    logic [WORD_W-1:0] data;
  } pixel_t;

  typedef struct packed {
    logic [WORD_W-1:0]  operation;
    logic [WORD_W-1:0]  control;
    logic [CLAMP_W-1:0] clamp;
    logic [GAIN_W-1:0]  gain;
    logic [WORD_W-1:0]  startup;
  } regs_t;

  localparam regs_t REGS_RESET = '{RESET_WORD, RESET_WORD, RESET_CLAMP, RESET_GAIN, RESET_WORD};

  typedef enum logic { SER_ADDR, SER_DATA } ser_state_t;
  typedef enum logic { POR_BUSY, POR_READY } por_state_t;

  function automatic logic [GAIN_DB_W-1:0] gain_db(input logic [GAIN_W-1:0] code);
    gain_db = GAIN_DB_W'(code) * GAIN_STEP + GAIN_OFFSET;
  endfunction

  function automatic logic [WORD_W-1:0] to_gray(input logic [WORD_W-1:0] x);
    to_gray = x ^ (x >> 1);
  endfunction

endpackage

// file: src/afe_output_ctrl.sv
// Digital control of a CCD front end: serial register link, power-on calibration hold-off,
// gain mapping, clamp/blanking arbitration and the output data pipeline.
// Assumes all pins are asynchronous to sys_clk_in and change slower than a few system cycles.
`timescale 1ns/1ps
`default_nettype none
module afe_output_ctrl
  import afe_ctrl_pkg::*;
#(
  parameter int POR_CYCLES_P = POR_CYCLES
) (
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic                  serial_clock_in,
  input  wire logic                  serial_load_strobe_in,
  input  wire logic                  serial_data_input_in,
  input  wire logic                  output_data_clock_in,
  input  wire logic                  pixel_blanking_input_in,
  input  wire logic                  black_clamp_pulse_in,
  input  wire logic [WORD_W-1:0]     adc_sample_in,
  output logic      [WORD_W-1:0]     data_out,
  output logic                       data_oe_out,
  output logic                       clamp_active_out,
  output logic      [CLAMP_W-1:0]    clamp_level_out,
  output logic      [GAIN_W-1:0]     gain_code_out,
  output logic      [GAIN_DB_W-1:0]  gain_db_out,
  output logic      [1:0]            power_mode_out,
  output logic                       cal_busy_out,
  output logic                       startup_written_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only stage two and later are read by logic.

  logic [2:0] sck_sync, load_sync, dclk_sync;
  logic [1:0] ser_bit_sync, blank_sync, clamp_sync;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sck_sync     <= '0;
      load_sync    <= '1;
      dclk_sync    <= '0;
      ser_bit_sync <= '0;
      blank_sync   <= '1;
      clamp_sync   <= '1;
    end else begin
      sck_sync     <= {sck_sync[1:0], serial_clock_in};
      load_sync    <= {load_sync[1:0], serial_load_strobe_in};
      dclk_sync    <= {dclk_sync[1:0], output_data_clock_in};
      ser_bit_sync <= {ser_bit_sync[0], serial_data_input_in};
      blank_sync   <= {blank_sync[0], pixel_blanking_input_in};
      clamp_sync   <= {clamp_sync[0], black_clamp_pulse_in};
    end
  end

  wire sck_rise  = sck_sync[1] & ~sck_sync[2];
  wire load_high = load_sync[1];
  wire load_rise = load_sync[1] & ~load_sync[2];
  wire dclk_rise = dclk_sync[1] & ~dclk_sync[2];
  wire ser_bit   = ser_bit_sync[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Power-on calibration hold-off.

  por_state_t           por_state;
  logic [POR_CNT_W-1:0] por_cnt;
  wire                  busy = (por_state == POR_BUSY);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      por_state <= POR_BUSY;
      por_cnt   <= '0;
    end else if (busy) begin
      if (por_cnt == POR_CNT_W'(POR_CYCLES_P - 1)) begin
        por_state <= POR_READY;
      end else begin
        por_cnt <= por_cnt + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial receiver: 4 address bits then 12-bit words, LSB first, address auto-increments.

  ser_state_t            ser_state;
  logic [1:0]            bit_hi;
  logic [3:0]            bit_cnt;
  logic [ADDR_W-1:0]     addr_sh, wr_addr;
  logic [WORD_W-1:0]     word_sh;
  logic [NUM_REGS-1:0]   pend;
  regs_t                 shadow, regs;

  wire [WORD_W-1:0] next_word = {ser_bit, word_sh[WORD_W-1:1]};
  wire [ADDR_W-1:0] next_addr = {ser_bit, addr_sh[ADDR_W-1:1]};
  wire              word_done = (ser_state == SER_DATA) && (bit_cnt == 4'hb);

  // The receiver is held idle while calibrating, so early traffic is simply dropped.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ser_state <= SER_ADDR;
      bit_cnt   <= '0;
      addr_sh   <= '0;
      wr_addr   <= '0;
      word_sh   <= '0;
      pend      <= '0;
      shadow    <= REGS_RESET;
    end else if (busy || load_high) begin
      ser_state <= SER_ADDR;
      bit_cnt   <= '0;
      if (busy || load_rise) pend <= '0;
    end else if (sck_rise) begin
      unique case (ser_state)
        SER_ADDR: begin
          addr_sh <= next_addr;
          bit_cnt <= (bit_cnt == 4'h3) ? 4'h0 : bit_cnt + 4'h1;
          if (bit_cnt == 4'h3) begin
            ser_state <= SER_DATA;
            wr_addr   <= next_addr;
          end
        end
        SER_DATA: begin
          word_sh <= next_word;
          bit_cnt <= word_done ? 4'h0 : bit_cnt + 4'h1;
          if (word_done) begin
            wr_addr <= wr_addr + 1'b1;
            case (wr_addr)
              ADDR_OPERATION: begin shadow.operation <= next_word; pend[SLOT_OPERATION] <= 1'b1; end
              ADDR_CONTROL:   begin shadow.control <= next_word; pend[SLOT_CONTROL] <= 1'b1; end
              ADDR_CLAMP:     begin shadow.clamp <= next_word[CLAMP_W-1:0]; pend[SLOT_CLAMP] <= 1'b1; end
              ADDR_GAIN:      begin shadow.gain <= next_word[GAIN_W-1:0]; pend[SLOT_GAIN] <= 1'b1; end
              ADDR_STARTUP:   begin shadow.startup <= next_word; pend[SLOT_STARTUP] <= 1'b1; end
              default:        ;
            endcase
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Live registers: updated together on the load strobe rise.

  wire soft_reset = pend[SLOT_OPERATION] && shadow.operation[OP_SOFT_RESET];

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      regs <= REGS_RESET;
    end else if (busy) begin
      regs <= REGS_RESET;
    end else if (load_rise) begin
      if (soft_reset) begin
        regs <= REGS_RESET;
      end else begin
        if (pend[SLOT_OPERATION]) regs.operation <= shadow.operation;
        if (pend[SLOT_CONTROL])   regs.control   <= shadow.control;
        if (pend[SLOT_CLAMP])     regs.clamp     <= shadow.clamp;
        if (pend[SLOT_GAIN])      regs.gain      <= shadow.gain;
        if (pend[SLOT_STARTUP])   regs.startup   <= shadow.startup;
      end
    end
  end

  // The mapped gain is registered from the shadow code on the same strobe rise that loads the live code, so it never lags the code.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gain_db_out <= GAIN_OFFSET;
    end else if (busy || (load_rise && soft_reset)) begin
      gain_db_out <= gain_db(RESET_GAIN);
    end else if (load_rise && pend[SLOT_GAIN]) begin
      gain_db_out <= gain_db(shadow.gain);
    end
  end

  assign gain_code_out       = regs.gain;
  assign clamp_level_out     = regs.clamp;
  assign power_mode_out      = regs.operation[OP_POWER_LSB+:2];
  assign cal_busy_out        = busy;
  assign startup_written_out = (regs.startup == STARTUP_VALUE);
  assign data_oe_out         = ~regs.control[CTL_OUT_HIZ];

  ////////////////////////////////////////////////////////////////////////////////
  // Clamp and blanking arbitration, output pipeline.

  // Polarity bit 0 means active low; an idle blanking pin therefore never blanks.
  wire blank_pin  = regs.control[CTL_BLANK_POL] ? blank_sync[1] : ~blank_sync[1];
  wire clamp_pin  = regs.control[CTL_CLAMP_POL] ? clamp_sync[1] : ~clamp_sync[1];
  wire blank_now  = blank_pin & ~clamp_pin;
  assign clamp_active_out = clamp_pin & ~regs.operation[OP_CLAMP_OFF] & ~busy;

  pixel_t pix_in, pix_tail;
  assign pix_in = '{blank: blank_now, data: adc_sample_in};

  pixel_delay_line #(
    .DEPTH      (PIPE_DEPTH - 1)
  ) u_delay (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .advance_in (dclk_rise),
    .pixel_in   (pix_in),
    .pixel_out  (pix_tail)
  );

  wire [WORD_W-1:0] blank_word = regs.operation[OP_BLANK_LEVEL] ? WORD_W'(regs.clamp) : '0;
  wire [WORD_W-1:0] live_word  = regs.control[CTL_GRAY] ? to_gray(pix_tail.data) : pix_tail.data;
  wire [WORD_W-1:0] next_data  = pix_tail.blank ? blank_word : live_word;

  // The final register is the ninth stage.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_out <= '0;
    end else if (dclk_rise) begin
      data_out <= next_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_gain_map;
    ##1 gain_db_out == gain_db(regs.gain);
  endproperty
  a_gain_map: assert property (p_gain_map) else $error("gain dB mapping mismatch");

  property p_clamp_wins;
    clamp_pin |-> !blank_now;
  endproperty
  a_clamp_wins: assert property (p_clamp_wins) else $error("blanking not overridden by clamp");

  property p_blank_zero;
    dclk_rise && pix_tail.blank && !regs.operation[OP_BLANK_LEVEL] |=> data_out == '0;
  endproperty
  a_blank_zero: assert property (p_blank_zero) else $error("blanked word not zero");

  property p_blank_level;
    dclk_rise && pix_tail.blank && regs.operation[OP_BLANK_LEVEL] |=> data_out == WORD_W'($past(regs.clamp));
  endproperty
  a_blank_level: assert property (p_blank_level) else $error("blanked word not clamp level");

  property p_busy_defaults;
    busy |=> regs == REGS_RESET;
  endproperty
  a_busy_defaults: assert property (p_busy_defaults) else $error("register changed during calibration");

  property p_por_end;
    busy && por_cnt == POR_CNT_W'(POR_CYCLES_P - 1) |=> !busy ##1 !busy;
  endproperty
  a_por_end: assert property (p_por_end) else $error("calibration did not end on time");

  property p_load_gain;
    !busy && load_rise && pend[SLOT_GAIN] && !soft_reset |=> regs.gain == $past(shadow.gain);
  endproperty
  a_load_gain: assert property (p_load_gain) else $error("gain not loaded on strobe rise");

  property p_hold_no_strobe;
    !load_rise && !busy |=> $stable(regs);
  endproperty
  a_hold_no_strobe: assert property (p_hold_no_strobe) else $error("register changed without strobe");

  c_blank_out: cover property (dclk_rise && pix_tail.blank);
  c_soft_reset: cover property (!busy && load_rise && soft_reset);
  c_gain_write: cover property (!busy && load_rise && pend[SLOT_GAIN]);
  c_startup: cover property ($rose(startup_written_out));

endmodule // afe_output_ctrl
`default_nettype wire

// file: src/pixel_delay_line.sv
// Fixed-depth delay line for pixel words with their blanking flag.
// Assumes the caller supplies a one-cycle advance enable per output data clock rising edge.
`timescale 1ns/1ps
`default_nettype none
module pixel_delay_line
  import afe_ctrl_pkg::*;
#(
  parameter int DEPTH = PIPE_DEPTH - 1
) (
  input  wire logic   sys_clk_in,
  input  wire logic   reset_n_in,
  input  wire logic   advance_in,
  input  wire pixel_t pixel_in,
  output var pixel_t  pixel_out
);

  pixel_t stages [DEPTH];

  // Blanking travels with its word so substituted outputs line up with the blanked pixels.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < DEPTH; i++) stages[i] <= '0;
    end else if (advance_in) begin
      stages[0] <= pixel_in;
      for (int i = 1; i < DEPTH; i++) stages[i] <= stages[i-1];
    end
  end

  assign pixel_out = stages[DEPTH-1];

  property p_first_stage;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      advance_in |=> stages[0] == $past(pixel_in);
  endproperty
  a_first_stage: assert property (p_first_stage) else $error("delay line did not capture the input pixel");

endmodule // pixel_delay_line
`default_nettype wire

// file: test/host_asic_model.sv
// Model of the far side: a serial-programming host plus the image ASIC's pixel and timing source.
// Assumes sys_clk_in is the block's system clock; every pin changes on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module host_asic_model
  import afe_ctrl_pkg::*;
(
  input  wire logic         sys_clk_in,
  output logic              serial_clock_out,
  output logic              serial_load_strobe_out,
  output logic              serial_data_out,
  output logic              output_data_clock_out,
  output logic              blank_pin_out,
  output logic              clamp_pin_out,
  output logic [WORD_W-1:0] sample_out
);
  initial begin
    serial_clock_out = 1'b0;
    serial_load_strobe_out = 1'b1;
    serial_data_out = 1'b0;
    output_data_clock_out = 1'b0;
    blank_pin_out = 1'b1;
    clamp_pin_out = 1'b1;
    sample_out = 12'h000;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask

  // Every level stands four system cycles, one more than the block's resampling needs.
  task automatic send_bit(input logic b);
    serial_data_out = b;
    serial_clock_out = 1'b0;
    hold(4);
    serial_clock_out = 1'b1;
    hold(4);
  endtask

  task automatic write_reg(input logic [ADDR_W-1:0] addr, input logic [WORD_W-1:0] word);
    serial_load_strobe_out = 1'b0;
    hold(4);
    for (int i = 0; i < ADDR_W; i++) send_bit(addr[i]);
    for (int i = 0; i < WORD_W; i++) send_bit(word[i]);
    serial_clock_out = 1'b0;
    hold(4);
    serial_load_strobe_out = 1'b1;
    // A released data line must not keep looking valid, so it flips.
    serial_data_out = ~word[WORD_W-1];
    hold(8);
  endtask

  task automatic pixel(input logic [WORD_W-1:0] s, input logic blank_n, input logic clamp_n);
    sample_out = s;
    blank_pin_out = blank_n;
    clamp_pin_out = clamp_n;
    output_data_clock_out = 1'b1;
    hold(4);
    output_data_clock_out = 1'b0;
    hold(4);
  endtask
endmodule // host_asic_model
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for afe_output_ctrl with the host and ASIC model on its pins.
// Assumes a shortened power-on count; blanking and clamp pins keep their active-low reset polarity.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import afe_ctrl_pkg::*;
;
  localparam int POR_SIM = 400;
  typedef struct {logic [WORD_W-1:0] sample; logic blank_n; logic [WORD_W-1:0] want;} row_t;
  logic                 sys_clk_in;
  logic                 reset_n_in;
  logic                 sck, load_strobe, sdi, dclk, blank_n, clamp_n;
  logic [1:0]           power_mode_out;
  logic [WORD_W-1:0]    sample;
  logic [WORD_W-1:0]    data_out;
  logic                 data_oe_out, clamp_active_out, cal_busy_out, startup_written_out;
  logic [CLAMP_W-1:0]   clamp_level_out;
  logic [GAIN_W-1:0]    gain_code_out;
  logic [GAIN_DB_W-1:0] gain_db_out;
  int                   fails, comparisons, n;
  logic [GAIN_W-1:0]    codes [4] = '{10'h000, 10'h001, 10'h200, 10'h3ff};
  row_t rows [12] = '{'{12'h123, 1'b1, 12'h123}, '{12'hfff, 1'b0, 12'h000}, '{12'h001, 1'b1, 12'h001},
    '{12'h800, 1'b0, 12'h000}, '{12'h7ff, 1'b0, 12'h000}, '{12'hfff, 1'b1, 12'hfff},
    '{12'h000, 1'b1, 12'h000}, '{12'h5a5, 1'b0, 12'h000}, '{12'ha5a, 1'b1, 12'ha5a},
    '{12'h3c3, 1'b1, 12'h3c3}, '{12'h444, 1'b0, 12'h000}, '{12'h0f0, 1'b1, 12'h0f0}};

  host_asic_model host (.sys_clk_in(sys_clk_in), .serial_clock_out(sck), .serial_load_strobe_out(load_strobe),
    .serial_data_out(sdi), .output_data_clock_out(dclk), .blank_pin_out(blank_n),
    .clamp_pin_out(clamp_n), .sample_out(sample));

  afe_output_ctrl #(.POR_CYCLES_P(POR_SIM)) dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .serial_clock_in(sck), .serial_load_strobe_in(load_strobe), .serial_data_input_in(sdi),
    .output_data_clock_in(dclk), .pixel_blanking_input_in(blank_n), .black_clamp_pulse_in(clamp_n),
    .adc_sample_in(sample), .data_out(data_out), .data_oe_out(data_oe_out),
    .clamp_active_out(clamp_active_out), .clamp_level_out(clamp_level_out),
    .gain_code_out(gain_code_out), .gain_db_out(gain_db_out), .power_mode_out(power_mode_out),
    .cal_busy_out(cal_busy_out), .startup_written_out(startup_written_out));

  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk(input logic [GAIN_DB_W-1:0] got, input logic [GAIN_DB_W-1:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // The hang limit is over ten times the two thousand or so cycles the tests need.
  initial begin
    repeat (40000) @(posedge sys_clk_in);
    fails++;
    report_and_stop();
  end

  initial begin
    reset_n_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    chk(clamp_level_out, 14'h0080, "clamp reset");
    chk(gain_code_out, 14'h0000, "gain reset");
    chk(gain_db_out, 14'h0424, "gain db reset");
    reset_n_in = 1'b1;
    // A whole frame sent while calibrating must leave the gain untouched.
    host.write_reg(ADDR_GAIN, 12'h3ff);
    chk(cal_busy_out, 14'h0001, "busy during calibration");
    chk(gain_code_out, 14'h0000, "write while busy");
    n = 144;
    while (cal_busy_out !== 1'b0 && n < 2 * POR_SIM) begin
      @(negedge sys_clk_in);
      n++;
    end
    chk(14'(n), 14'(POR_SIM), "calibration length");
    chk(startup_written_out, 14'h0000, "startup before write");
    host.write_reg(ADDR_STARTUP, 12'h838);
    chk(startup_written_out, 14'h0001, "startup write");
    chk(data_oe_out, 14'h0001, "outputs enabled");
    foreach (codes[i]) begin
      host.write_reg(ADDR_GAIN, {2'b00, codes[i]});
      chk(gain_code_out, codes[i], "gain code");
      chk(gain_db_out, 14'(codes[i]) * 14'h0007 + 14'h0424, "gain db");
    end
    for (int i = 0; i < 20; i++) begin
      if (i < 12) host.pixel(rows[i].sample, rows[i].blank_n, 1'b1);
      else host.pixel(12'(i * 97), 1'b1, 1'b1);
      if (i >= 8) chk(data_out, rows[i - 8].want, "pipeline word");
    end
    // Clamp and blanking overlap for a whole pipeline length: the clamp must win.
    for (int i = 0; i < 9; i++) host.pixel(12'h5a5, 1'b0, 1'b0);
    chk(data_out, 14'h05a5, "clamp over blanking");
    chk(clamp_active_out, 14'h0001, "clamp active");
    host.write_reg(ADDR_CLAMP, 12'h037);
    host.write_reg(ADDR_OPERATION, 12'h04a);
    chk(power_mode_out, 14'h0001, "power mode field");
    chk(clamp_active_out, 14'h0000, "clamp disabled");
    for (int i = 0; i < 9; i++) host.pixel(12'hfff, 1'b0, 1'b1);
    chk(data_out, 14'h0037, "blank to clamp level");
    // Gray coding and the three-state select touch only unblanked words and the enable.
    host.write_reg(ADDR_CONTROL, 12'h050);
    for (int i = 0; i < 9; i++) host.pixel(12'h5a5, 1'b1, 1'b1);
    chk(data_out, 14'h0777, "gray coded word");
    chk(data_oe_out, 14'h0000, "outputs three-stated");
    host.write_reg(ADDR_OPERATION, 12'h001);
    chk(clamp_level_out, 14'h0080, "soft reset clamp");
    chk(gain_code_out, 14'h0000, "soft reset gain");
    chk(data_oe_out, 14'h0001, "soft reset enable");
    for (int i = 0; i < 9; i++) host.pixel(12'hfff, 1'b0, 1'b1);
    chk(data_out, 14'h0000, "blank to zero after reset");
    // A reset in mid-run must restart calibration.
    reset_n_in = 1'b0;
    @(negedge sys_clk_in);
    chk(cal_busy_out, 14'h0001, "busy in mid-run reset");
    reset_n_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    chk(cal_busy_out, 14'h0001, "busy after mid-run reset");
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
